// file: common/adcif_pkg.sv
// Shared constants and types for the converter's serial register port.
// Assumes one system clock; the bus pins are sampled, never used as clocks.
package adcif_pkg;

   localparam int DATA_W = 16;
   localparam int PTR_W = 8;

   // Pointer select values
   localparam logic [1:0] PTR_CONV = 2'h0;
   localparam logic [1:0] PTR_CFG = 2'h1;

   // Reset values
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [7:0] PTR_RESET = 8'h00;

   // Bus address: base plus the select offset from the address pin
   localparam logic [6:0] ADDR_BASE = 7'h48;
   localparam logic [6:0] SEL_GND = 7'h00;
   localparam logic [6:0] SEL_VDD = 7'h01;
   localparam logic [6:0] SEL_SDA = 7'h02;
   localparam logic [6:0] SEL_SCL = 7'h03;

   // Byte positions inside a transaction
   localparam logic [2:0] IDX_ADDR = 3'h0;
   localparam logic [2:0] IDX_PTR = 3'h1;
   localparam logic [2:0] IDX_MSB = 3'h2;
   localparam logic [2:0] IDX_LSB = 3'h3;
   localparam logic [2:0] IDX_EXTRA = 3'h4;

   // Bit counting
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;

   // Hold time the master keeps on the data line when it selects the address
   localparam int CLK_PERIOD_NS = 8;
   localparam int SDA_HOLD_NS = 100;
   localparam int SDA_HOLD_CYC = (SDA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic scl;
      logic sda;
      logic addr;
   } adcif_pins_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK
   } adcif_state_e;

endpackage

// file: core/adcif_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the reset input is already released synchronously to clk.
`timescale 1ns/1ps
module adcif_sync
   import adcif_pkg::*;
#(
   parameter int W = 3
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic meta;
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               // Idle bus level, so no false clock edge follows reset
               meta <= 1'b1;
               q[i] <= 1'b1;
            end
            else
            begin
               meta <= d[i];
               q[i] <= meta;
            end
         end
      end
   endgenerate

endmodule

// file: core/adcif_top.sv
// Serial target port of the converter: pointer register, configuration
// register and read-back of the conversion result over a two-wire bus.
// Assumes bus pins are asynchronous to sys_clk and much slower than it;
// conv_result comes from logic on sys_clk.
//
// Overview of operation
// RQ1: Master frames every transaction with START and STOP.
// RQ2: Device never drives or stretches the clock line; data line only.
// RQ3: Address pin tied to ground, supply, clock or data picks one of four addresses.
// RQ4: Master prefers non-data selections; with data select holds data low 100 ns.
// RQ5: First byte is 7-bit address plus direction bit; low means write.
// RQ6: Byte after the address byte in a write becomes the pointer.
// RQ7: Third and fourth write bytes, MSB first, go to pointer-selected register.
// RQ8: Pointer zero selects conversion result, pointer one selects configuration.
// RQ9: Address plus pointer only updates pointer, modifies no register.
// RQ10: Read returns two bytes of pointed register, MSB then LSB.
// RQ11: Pointer is kept across transactions until a new one is written.
// RQ12: Acknowledge own address and every written byte; ignore other targets.
`timescale 1ns/1ps
module adcif_top
   import adcif_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_sel,
   input wire logic [15:0] conv_result,
   output logic [15:0] config_value,
   output logic config_wr
);

   // Reset release
   logic [1:0] rst_ff;
   logic [1:0] next_rst_ff;
   logic rst_int_n;

   always_comb
   begin
      next_rst_ff = {rst_ff[0], 1'b1};
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_ff <= 2'h0;
      else
         rst_ff <= next_rst_ff;
   end

   assign rst_int_n = rst_ff[1];

   // Pin sampling; all three pins share one delay so they compare cleanly
   adcif_pins_s pins_raw;
   adcif_pins_s pins_s;

   assign pins_raw.scl = scl;
   assign pins_raw.sda = sda_in;
   assign pins_raw.addr = addr_sel;

   adcif_sync #(.W(3)) u_sync (
      .clk(sys_clk),
      .rst_n(rst_int_n),
      .d(pins_raw),
      .q(pins_s)
   );

   // Only a data output exists for the data line; the clock is never driven [RQ2]
   assign sda_out = 1'b0;

   adcif_state_e state, next_state;
   logic scl_d, next_scl_d;
   logic sda_d, next_sda_d;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [2:0] byte_idx, next_byte_idx;
   logic [7:0] rx_shift, next_rx_shift;
   logic [15:0] tx_shift, next_tx_shift;
   logic [7:0] ptr, next_ptr;
   logic [7:0] data_hi, next_data_hi;
   logic [15:0] cfg, next_cfg;
   logic next_cfg_wr;
   logic next_sda_oe;
   logic rd_mode, next_rd_mode;
   logic master_ack, next_master_ack;
   logic seen_hi, next_seen_hi;
   logic seen_lo, next_seen_lo;
   logic ne_scl, next_ne_scl;
   logic ne_sda, next_ne_sda;

   logic scl_rise, scl_fall, start_ev, stop_ev;
   logic [6:0] dev_addr;
   logic [15:0] rd_word;

   assign scl_rise = pins_s.scl & ~scl_d;
   assign scl_fall = ~pins_s.scl & scl_d;
   assign start_ev = pins_s.scl & scl_d & sda_d & ~pins_s.sda; // [RQ1]
   assign stop_ev = pins_s.scl & scl_d & ~sda_d & pins_s.sda; // [RQ1]

   // Address pin classified by what it tracked since START [RQ3]
   always_comb
   begin
      if (!seen_hi)
         dev_addr = ADDR_BASE + SEL_GND;
      else if (!seen_lo)
         dev_addr = ADDR_BASE + SEL_VDD;
      else if (!ne_scl)
         dev_addr = ADDR_BASE + SEL_SCL;
      else if (!ne_sda)
         dev_addr = ADDR_BASE + SEL_SDA;
      else
         // Pin followed neither bus line; fall back rather than guess
         dev_addr = ADDR_BASE + SEL_GND;
   end

   // Register read mux [RQ8]
   always_comb
   begin
      if (ptr[1:0] == PTR_CONV)
         rd_word = conv_result;
      else if (ptr[1:0] == PTR_CFG)
         rd_word = cfg;
      else
         rd_word = 16'h0000;
   end

   always_comb
   begin
      next_state = state;
      next_scl_d = pins_s.scl;
      next_sda_d = pins_s.sda;
      next_bit_cnt = bit_cnt;
      next_byte_idx = byte_idx;
      next_rx_shift = rx_shift;
      next_tx_shift = tx_shift;
      next_ptr = ptr;
      next_data_hi = data_hi;
      next_cfg = cfg;
      next_cfg_wr = 1'b0;
      next_sda_oe = sda_oe;
      next_rd_mode = rd_mode;
      next_master_ack = master_ack;
      next_seen_hi = seen_hi | pins_s.addr;
      next_seen_lo = seen_lo | ~pins_s.addr;
      next_ne_scl = ne_scl | (pins_s.addr ^ pins_s.scl);
      next_ne_sda = ne_sda | (pins_s.addr ^ pins_s.sda);
      if (stop_ev)
      begin
         next_state = ST_IDLE;
         next_sda_oe = 1'b0;
      end
      else if (start_ev)
      begin
         // Repeated START also lands here
         next_state = ST_RX;
         next_bit_cnt = 4'h0;
         next_byte_idx = IDX_ADDR;
         next_sda_oe = 1'b0;
         next_rd_mode = 1'b0;
         next_seen_hi = 1'b0;
         next_seen_lo = 1'b0;
         next_ne_scl = 1'b0;
         next_ne_sda = 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               next_sda_oe = 1'b0;
            end
            ST_RX:
            begin
               if (scl_rise)
               begin
                  next_rx_shift = {rx_shift[6:0], pins_s.sda};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               else if (scl_fall && bit_cnt == BITS_PER_BYTE)
               begin
                  next_bit_cnt = 4'h0;
                  next_state = ST_RX_ACK;
                  next_sda_oe = 1'b1; // [RQ12]
                  if (byte_idx != IDX_EXTRA)
                     next_byte_idx = byte_idx + 3'h1;
                  if (byte_idx == IDX_ADDR)
                  begin
                     if (rx_shift[7:1] != dev_addr) // [RQ5] [RQ12]
                     begin
                        next_state = ST_IDLE;
                        next_sda_oe = 1'b0;
                     end
                     else
                     begin
                        next_rd_mode = rx_shift[0]; // [RQ5]
                        // Snapshot keeps MSB and LSB from the same value
                        next_tx_shift = rd_word; // [RQ11]
                     end
                  end
                  else if (byte_idx == IDX_PTR)
                     next_ptr = rx_shift; // [RQ6] [RQ9]
                  else if (byte_idx == IDX_MSB)
                     next_data_hi = rx_shift; // [RQ7]
                  else if (byte_idx == IDX_LSB && ptr[1:0] == PTR_CFG)
                  begin
                     // Conversion result is read-only; its writes are dropped
                     next_cfg = {data_hi, rx_shift}; // [RQ7] [RQ8]
                     next_cfg_wr = 1'b1;
                  end
               end
            end
            ST_RX_ACK:
            begin
               if (scl_fall)
               begin
                  next_bit_cnt = 4'h0;
                  if (rd_mode)
                  begin
                     next_state = ST_TX;
                     next_sda_oe = ~tx_shift[15]; // [RQ10]
                  end
                  else
                  begin
                     next_state = ST_RX;
                     next_sda_oe = 1'b0;
                  end
               end
            end
            ST_TX:
            begin
               if (scl_fall)
               begin
                  next_bit_cnt = bit_cnt + 4'h1;
                  next_tx_shift = {tx_shift[14:0], tx_shift[15]}; // [RQ10]
                  if (bit_cnt == LAST_TX_BIT)
                  begin
                     next_state = ST_TX_ACK;
                     next_sda_oe = 1'b0;
                  end
                  else
                     next_sda_oe = ~tx_shift[14];
               end
            end
            ST_TX_ACK:
            begin
               if (scl_rise)
                  next_master_ack = ~pins_s.sda;
               else if (scl_fall)
               begin
                  next_bit_cnt = 4'h0;
                  if (master_ack)
                  begin
                     next_state = ST_TX;
                     next_sda_oe = ~tx_shift[15];
                  end
                  else
                     next_state = ST_IDLE;
               end
            end
            default:
            begin
               next_state = ST_IDLE;
               next_sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         state <= ST_IDLE;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         bit_cnt <= 4'h0;
         byte_idx <= IDX_ADDR;
         rx_shift <= 8'h00;
         tx_shift <= 16'h0000;
         ptr <= PTR_RESET;
         data_hi <= 8'h00;
         cfg <= CFG_RESET;
         config_wr <= 1'b0;
         sda_oe <= 1'b0;
         rd_mode <= 1'b0;
         master_ack <= 1'b0;
         seen_hi <= 1'b0;
         seen_lo <= 1'b0;
         ne_scl <= 1'b0;
         ne_sda <= 1'b0;
      end
      else
      begin
         state <= next_state;
         scl_d <= next_scl_d;
         sda_d <= next_sda_d;
         bit_cnt <= next_bit_cnt;
         byte_idx <= next_byte_idx;
         rx_shift <= next_rx_shift;
         tx_shift <= next_tx_shift;
         ptr <= next_ptr;
         data_hi <= next_data_hi;
         cfg <= next_cfg;
         config_wr <= next_cfg_wr;
         sda_oe <= next_sda_oe;
         rd_mode <= next_rd_mode;
         master_ack <= next_master_ack;
         seen_hi <= next_seen_hi;
         seen_lo <= next_seen_lo;
         ne_scl <= next_ne_scl;
         ne_sda <= next_ne_sda;
      end
   end

   assign config_value = cfg;

endmodule

// file: test/adcif_chk.sv
// Pin-level assertions on the serial register port.
// Assumes it is bound onto adcif_top.
`timescale 1ns/1ps
module adcif_chk
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic addr_sel,
   input wire logic [15:0] conv_result,
   input wire logic [15:0] config_value,
   input wire logic config_wr
);
   logic [4:0] hi_cnt;
   logic [4:0] next_hi_cnt;
   // Saturates so a long idle never wraps back
   always_comb
   begin
      next_hi_cnt = (hi_cnt == 5'h1F) ? hi_cnt : hi_cnt + 5'h01;
      if (!scl)
         next_hi_cnt = 5'h00;
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         hi_cnt <= 5'h00;
      else
         hi_cnt <= next_hi_cnt;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_data_only: assert property (sda_out == 1'b0)
      else $error("data value not open drain");
   a_ack_rise: assert property ($rose(sda_oe) |-> !scl && !$past(scl, 2))
      else $error("data driven while clock high");
   a_oe_fall: assert property ($fell(sda_oe) |-> !scl)
      else $error("data released while clock high");
   a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*8])
      else $error("driven bit too short");
   a_idle_free: assert property (hi_cnt > 5'h0C |-> !sda_oe)
      else $error("data held while bus idle");
   a_wr_pulse: assert property (config_wr |=> !config_wr)
      else $error("write pulse too long");
   a_wr_timing: assert property (config_wr |-> !scl && !$past(scl, 3))
      else $error("write pulse off clock low");
   a_cfg_change: assert property ($changed(config_value) |-> ##[0:10] config_wr)
      else $error("configuration changed silently");
endmodule

// file: test/adcif_mst.sv
// Bus master model: drives the clock and its side of the data line.
// Assumes the data line is resolved outside with a pull-up.
`timescale 1ns/1ps
module adcif_mst
(
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_m
);
   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic start();
      sda_m = 1'b1;
      w(5);
      scl = 1'b1;
      w(5);
      sda_m = 1'b0;
      w(5);
      scl = 1'b0;
   endtask
   task automatic stop();
      w(13);
      sda_m = 1'b0;
      w(2);
      scl = 1'b1;
      w(5);
      sda_m = 1'b1;
      w(20);
   endtask
   task automatic xbit(input logic b, output logic r);
      w(13); // Data held past the fall for the data-pin address
      sda_m = b;
      w(2);
      scl = 1'b1;
      w(3);
      r = sda;
      w(2);
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         xbit(b[i], r);
      xbit(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         xbit(1'b1, r);
         b[i] = r;
      end
      xbit(nack, r);
   endtask
endmodule

// file: test/test_adcif_top.sv
// Self-checking bench for the serial register port.
// Assumes adcif_mst as bus master and adcif_chk bound below.
`timescale 1ns/1ps
module test_adcif_top
   import adcif_pkg::*;
   ;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] amode = 2'h0;
   logic [15:0] conv_result = 16'hA55A;
   logic scl, sda_m, sda_out, sda_oe, config_wr;
   logic [15:0] config_value;
   wire logic sda_in;
   wire logic addr_sel;
   int err_count = 0;
   int check_count = 0;
   int wr_n = 0;
   localparam logic [6:0] A0 = ADDR_BASE + SEL_GND;
   assign sda_in = sda_m & ~(sda_oe & ~sda_out);
   assign addr_sel = amode == 2'h0 ? 1'b0 : amode == 2'h1 ? 1'b1 : amode == 2'h2 ? sda_in : scl;
   adcif_top adcif_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .conv_result(conv_result),
      .config_value(config_value), .config_wr(config_wr));
   adcif_mst adcif_mst_i (.clk(sys_clk), .sda(sda_in), .scl(scl), .sda_m(sda_m));
   initial
      forever #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      if (config_wr === 1'b1)
         wr_n++;
   task automatic cmp16(input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmp1(input logic e, input logic g);
      cmp16({15'h0, e}, {15'h0, g});
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic txw(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
      input logic full, input logic ea);
      logic k;
      adcif_mst_i.start();
      adcif_mst_i.wbyte({a, 1'b0}, k);
      cmp1(ea, k);
      if (ea)
      begin
         adcif_mst_i.wbyte(p, k);
         cmp1(1'b1, k);
         for (int i = 1; i >= 0 && full; i--)
         begin
            adcif_mst_i.wbyte(d[8*i+:8], k);
            cmp1(1'b1, k);
         end
      end
      adcif_mst_i.stop();
   endtask
   task automatic txr(input logic [6:0] a, input logic [15:0] e);
      logic k;
      logic [7:0] hi, lo;
      adcif_mst_i.start();
      adcif_mst_i.wbyte({a, 1'b1}, k);
      cmp1(1'b1, k);
      adcif_mst_i.rbyte(1'b0, hi);
      adcif_mst_i.rbyte(1'b1, lo);
      adcif_mst_i.stop();
      cmp16(e, {hi, lo});
   endtask
   task automatic sc_cfg();
      txw(A0, 8'h01, 16'h8483, 1'b1, 1'b1);
      cmp16(16'h8483, config_value);
      cmp1(1'b1, wr_n == 1);
   endtask
   task automatic sc_ptr();
      txw(A0, 8'h00, 16'h0000, 1'b0, 1'b1);
      cmp1(1'b1, wr_n == 1);
      txr(A0, 16'hA55A);
      conv_result = 16'h1234;
      txr(A0, 16'h1234);
   endtask
   task automatic sc_refuse();
      txw(A0, 8'h00, 16'hFFFF, 1'b1, 1'b1);
      txw(A0 + 7'h04, 8'h01, 16'h0000, 1'b1, 1'b0);
      cmp16(16'h8483, config_value);
      cmp1(1'b1, wr_n == 1);
      txr(A0, 16'h1234);
      txw(A0, 8'h01, 16'h0000, 1'b0, 1'b1);
      txr(A0, 16'h8483);
   endtask
   task automatic sc_addr();
      logic [6:0] sel [4];
      sel = '{SEL_GND, SEL_VDD, SEL_SDA, SEL_SCL};
      // Mode 2 follows the data line, mode 3 the clock line
      for (int m = 0; m < 4; m++)
      begin
         amode = 2'(m);
         txr(ADDR_BASE + sel[m], 16'h8483);
      end
   endtask
   initial
   begin
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge sys_clk);
      sc_cfg();
      sc_ptr();
      sc_refuse();
      sc_addr();
      summarize();
   end
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      err_count++;
      summarize();
   end
endmodule
bind adcif_top adcif_chk adcif_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .scl(scl),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
   .conv_result(conv_result), .config_value(config_value), .config_wr(config_wr));
